/* verilog/dbu_pkg.sv */
// package for the debug serial port status, interrupt and holding registers
package dbu_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_IRQ_SET = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_RX_HOLD = 8'h18;
	localparam logic [7:0] OFF_TX_HOLD = 8'h1c;
	localparam logic [7:0] OFF_BAUD = 8'h20;
	// shared status / interrupt bit positions
	localparam int B_RX_RDY = 0;
	localparam int B_TX_FREE = 1;
	localparam int B_RX_DMA_END = 3;
	localparam int B_TX_DMA_END = 4;
	localparam int B_OVERRUN = 5;
	localparam int B_FRAME = 6;
	localparam int B_PARITY = 7;
	localparam int B_TX_IDLE = 9;
	localparam int B_TX_BUF_EMPTY = 11;
	localparam int B_RX_BUF_FULL = 12;
	localparam int B_DCC_WRITE = 30;
	localparam int B_DCC_READ = 31;
	localparam logic [31:0] IRQ_BITS_MASK = 32'hc0001afb;
	// control register command bits
	localparam int C_RX_RESET = 2;
	localparam int C_TX_RESET = 3;
	localparam int C_RX_EN = 4;
	localparam int C_RX_DIS = 5;
	localparam int C_TX_EN = 6;
	localparam int C_TX_DIS = 7;
	localparam int C_CLR_ERR = 8;
	// reset values
	localparam logic [31:0] RST_MASK = 32'h00000000;
	localparam logic [15:0] RST_BAUD = 16'h0000;
	localparam logic [7:0] RST_CHAR = 8'h00;
	// oversampling: ratio of baud clock per bit tick
	localparam logic [4:0] OVERSAMPLE = 5'h10;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dbu_bus_req_t;

	typedef struct packed {
		logic rx_dma_end;
		logic tx_dma_end;
		logic tx_dma_buffer_empty;
		logic rx_dma_buffer_full;
		logic dcc_write_pending;
		logic dcc_read_pending;
	} dbu_side_in_t;

	typedef struct packed {
		logic [7:0] char_data;
		logic overrun_evt;
		logic frame_err;
		logic parity_err;
		logic valid;
	} dbu_rx_evt_t;

	typedef struct packed {
		logic [31:0] mask;
		logic [31:0] rdata;
		logic rx_en;
		logic tx_en;
		logic rx_char_ready;
		logic [7:0] rx_char_field;
		logic tx_pend;
		logic [7:0] tx_char_field;
		logic tx_start;
		logic overrun_flag;
		logic frame_flag;
		logic parity_error_flag;
		logic [15:0] baud_divisor;
		logic [15:0] div_cnt;
		logic [3:0] sub_cnt;
		logic baud_tick;
		logic irq;
	} dbu_state_t;
endpackage : dbu_pkg

/* verilog/dbu_regs.sv */
// register file: interrupt mask, status, holding registers, baud divider
`timescale 1ns/1ps
module dbu_regs (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register port
	input wire dbu_pkg::dbu_bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	// receiver and transmitter shifter side
	input wire dbu_pkg::dbu_rx_evt_t rx_evt,
	input wire logic shifter_busy,
	output logic tx_start,
	output logic [7:0] tx_char,
	output logic baud_tick,
	output logic rx_enabled,
	output logic tx_enabled,
	// dma and debug-channel status lines
	input wire dbu_pkg::dbu_side_in_t side_in,
	// interrupt level
	output logic irq
);
	import dbu_pkg::*;

	dbu_state_t st_ff;
	dbu_state_t nxt_st;
	dbu_side_in_t side_meta_ff;
	dbu_side_in_t side_sync_ff;
	logic [31:0] status;

	// side lines cross from other logic; two stages before use
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			side_meta_ff <= '0;
			side_sync_ff <= '0;
		end else begin
			side_meta_ff <= side_in;
			side_sync_ff <= side_meta_ff;
		end
	end

	function automatic logic hit(input dbu_bus_req_t r, input logic [7:0] off);
		hit = (r.addr == off);
	endfunction : hit

	always_comb begin
		status = '0;
		status[B_RX_RDY] = st_ff.rx_char_ready;
		status[B_TX_FREE] = st_ff.tx_en & ~st_ff.tx_pend;
		status[B_RX_DMA_END] = side_sync_ff.rx_dma_end;
		status[B_TX_DMA_END] = side_sync_ff.tx_dma_end;
		status[B_OVERRUN] = st_ff.overrun_flag;
		status[B_FRAME] = st_ff.frame_flag;
		status[B_PARITY] = st_ff.parity_error_flag;
		// launch cycle: shifter not yet busy, but the character is in flight
		status[B_TX_IDLE] = st_ff.tx_en & ~st_ff.tx_pend & ~st_ff.tx_start & ~shifter_busy;
		status[B_TX_BUF_EMPTY] = side_sync_ff.tx_dma_buffer_empty;
		status[B_RX_BUF_FULL] = side_sync_ff.rx_dma_buffer_full;
		status[B_DCC_WRITE] = side_sync_ff.dcc_write_pending;
		status[B_DCC_READ] = side_sync_ff.dcc_read_pending;
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tx_start = 1'b0;
		nxt_st.rdata = '0;
		if (bus_req.wr && hit(bus_req, OFF_IRQ_SET)) begin
			nxt_st.mask = st_ff.mask | (bus_req.wdata & IRQ_BITS_MASK);
		end
		if (bus_req.wr && hit(bus_req, OFF_IRQ_CLR)) begin
			nxt_st.mask = st_ff.mask & ~bus_req.wdata;
		end
		if (bus_req.wr && hit(bus_req, OFF_BAUD)) begin
			nxt_st.baud_divisor = bus_req.wdata[15:0];
		end
		if (bus_req.wr && hit(bus_req, OFF_CTRL)) begin
			if (bus_req.wdata[C_RX_EN] && !bus_req.wdata[C_RX_DIS]) begin
				nxt_st.rx_en = 1'b1;
			end
			if (bus_req.wdata[C_RX_DIS] || bus_req.wdata[C_RX_RESET]) begin
				nxt_st.rx_en = 1'b0;
			end
			if (bus_req.wdata[C_TX_EN] && !bus_req.wdata[C_TX_DIS]) begin
				nxt_st.tx_en = 1'b1;
			end
			if (bus_req.wdata[C_TX_DIS] || bus_req.wdata[C_TX_RESET]) begin
				nxt_st.tx_en = 1'b0;
			end
			// transmitter reset drops the waiting character
			if (bus_req.wdata[C_TX_RESET]) begin
				nxt_st.tx_pend = 1'b0;
			end
			if (bus_req.wdata[C_CLR_ERR]) begin
				nxt_st.overrun_flag = 1'b0;
				nxt_st.frame_flag = 1'b0;
				nxt_st.parity_error_flag = 1'b0;
			end
		end
		// holding register load; a write while one waits overwrites it
		if (bus_req.wr && hit(bus_req, OFF_TX_HOLD) && st_ff.tx_en) begin
			nxt_st.tx_char_field = bus_req.wdata[7:0];
			nxt_st.tx_pend = 1'b1;
		end
		// hand over to shifter once it is free
		if (st_ff.tx_pend && st_ff.tx_en && !shifter_busy && !st_ff.tx_start) begin
			nxt_st.tx_pend = 1'b0;
			nxt_st.tx_start = 1'b1;
		end
		if (bus_req.rd) begin
			case (bus_req.addr)
				OFF_IRQ_MASK: nxt_st.rdata = st_ff.mask;
				OFF_STATUS: nxt_st.rdata = status;
				OFF_RX_HOLD: nxt_st.rdata = {24'h000000, st_ff.rx_char_field};
				OFF_BAUD: nxt_st.rdata = {16'h0000, st_ff.baud_divisor};
				default: nxt_st.rdata = '0;
			endcase
			if (hit(bus_req, OFF_RX_HOLD)) begin
				nxt_st.rx_char_ready = 1'b0;
			end
		end
		if (!nxt_st.rx_en) begin
			nxt_st.rx_char_ready = 1'b0;
		end
		// hardware events win over the clear in the same cycle
		if (rx_evt.valid && st_ff.rx_en) begin
			nxt_st.rx_char_field = rx_evt.char_data;
			nxt_st.rx_char_ready = 1'b1;
			if (rx_evt.overrun_evt || st_ff.rx_char_ready) begin
				nxt_st.overrun_flag = 1'b1;
			end
			if (rx_evt.frame_err) begin
				nxt_st.frame_flag = 1'b1;
			end
			if (rx_evt.parity_err) begin
				nxt_st.parity_error_flag = 1'b1;
			end
		end
		// baud generator
		nxt_st.baud_tick = 1'b0;
		nxt_st.div_cnt = '0;
		nxt_st.sub_cnt = '0;
		if (st_ff.baud_divisor == 16'h0000) begin
			nxt_st.baud_tick = 1'b0;
		end else if (st_ff.baud_divisor == 16'h0001) begin
			nxt_st.baud_tick = 1'b1;
		end else begin
			nxt_st.sub_cnt = st_ff.sub_cnt;
			nxt_st.div_cnt = st_ff.div_cnt;
			if (st_ff.div_cnt >= st_ff.baud_divisor - 16'h0001) begin
				nxt_st.div_cnt = '0;
				nxt_st.sub_cnt = st_ff.sub_cnt + 4'h1;
				if ({1'b0, st_ff.sub_cnt} == OVERSAMPLE - 5'h01) begin
					nxt_st.baud_tick = 1'b1;
				end
			end else begin
				nxt_st.div_cnt = st_ff.div_cnt + 16'h0001;
			end
		end
		nxt_st.irq = |(status & st_ff.mask);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.mask <= RST_MASK;
			st_ff.baud_divisor <= RST_BAUD;
			st_ff.rx_char_field <= RST_CHAR;
			st_ff.tx_char_field <= RST_CHAR;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign bus_rdata = st_ff.rdata;
	assign tx_start = st_ff.tx_start;
	assign tx_char = st_ff.tx_char_field;
	assign baud_tick = st_ff.baud_tick;
	assign rx_enabled = st_ff.rx_en;
	assign tx_enabled = st_ff.tx_en;
	assign irq = st_ff.irq;
endmodule : dbu_regs

/* tb/dbu_regs_props.sv */
// port-level assertions for the register block
`timescale 1ns/1ps
module dbu_regs_props (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register port
	input wire dbu_pkg::dbu_bus_req_t bus_req,
	input wire logic [31:0] bus_rdata,
	// shifter and status side
	input wire logic shifter_busy,
	input wire logic tx_start,
	input wire logic baud_tick,
	input wire logic rx_enabled,
	input wire logic tx_enabled,
	input wire dbu_pkg::dbu_side_in_t side_in
);
	import dbu_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic wr_ctl = bus_req.wr && bus_req.addr == OFF_CTRL;
	wire logic [5:0] sv = {side_in.dcc_read_pending, side_in.dcc_write_pending,
		side_in.rx_dma_buffer_full, side_in.tx_dma_buffer_empty,
		side_in.tx_dma_end, side_in.rx_dma_end};
	AST_RD_IDLE: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_TX_LAUNCH: assert property (tx_start |-> !$past(shifter_busy) ##1 !tx_start)
		else $error("bad launch");
	AST_RX_OFF: assert property (wr_ctl && bus_req.wdata[C_RX_DIS] |=> !rx_enabled)
		else $error("receiver still on");
	AST_TX_ON: assert property (wr_ctl && bus_req.wdata[7:6] == 2'h1 && !bus_req.wdata[3]
		|=> tx_enabled)
		else $error("transmitter not on");
	AST_BAUD_ONE: assert property (bus_req.wr && bus_req.addr == OFF_BAUD
		&& bus_req.wdata[15:0] == 16'h1 |-> ##[2:3] baud_tick)
		else $error("no tick at divisor one");
	AST_MIRROR: assert property (bus_req.rd && bus_req.addr == OFF_STATUS
		&& $past(sv, 3) == sv && $past(sv, 2) == sv && $past(sv) == sv
		|=> {bus_rdata[31:30], bus_rdata[12:11], bus_rdata[4:3]} == $past(sv))
		else $error("status mirror bits wrong");
	AST_MASK_BITS: assert property (bus_req.rd && bus_req.addr == OFF_IRQ_MASK
		|=> (bus_rdata & ~IRQ_BITS_MASK) == 32'h0)
		else $error("mask view has undefined bits");
	AST_RX_UPPER: assert property (bus_req.rd && bus_req.addr == OFF_RX_HOLD
		|=> bus_rdata[31:8] == 24'h0)
		else $error("rx holding upper bits set");
endmodule : dbu_regs_props

/* tb/dbu_shifter_model.sv */
// far-side shifter model: busy for a fixed time after each launch
`timescale 1ns/1ps
module dbu_shifter_model #(
	parameter int BUSY_CYC = 30
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// launch handshake
	input wire logic tx_start,
	output logic shifter_busy
);
	int cnt_ff;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) cnt_ff <= 0;
		else if (tx_start) cnt_ff <= BUSY_CYC;
		else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
	end
	assign shifter_busy = cnt_ff != 0;
endmodule : dbu_shifter_model

/* tb/dbu_regs_tb.sv */
// self-checking bench for the register block
`timescale 1ns/1ps
module dbu_regs_tb;
	import dbu_pkg::*;
	logic clk_sys = 0, sys_rst = 1, shifter_busy, tx_start, baud_tick;
	logic rx_enabled, tx_enabled, irq, rd_q = 0;
	dbu_bus_req_t bus_req = '0;
	dbu_rx_evt_t rx_evt = '0;
	dbu_side_in_t side_in = '0;
	logic [31:0] bus_rdata, n, eq[$];
	logic [7:0] tx_char, c, cq[$];
	int miscompares = 0, comparisons = 0, seed = 50, cyc = 0, k;
	always #50 clk_sys = ~clk_sys;
	dbu_regs dbu_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .rx_evt(rx_evt), .shifter_busy(shifter_busy),
		.tx_start(tx_start), .tx_char(tx_char), .baud_tick(baud_tick),
		.rx_enabled(rx_enabled), .tx_enabled(tx_enabled), .side_in(side_in), .irq(irq));
	dbu_shifter_model dbu_shifter_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.tx_start(tx_start), .shifter_busy(shifter_busy));
	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) bus_req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		eq.push_back(e);
		@(posedge clk_sys) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys) bus_req <= '0;
	endtask : rd
	task automatic rxc(input logic [7:0] ch, input logic [2:0] f);
		@(posedge clk_sys) rx_evt <= {ch, f, 1'b1};
		@(posedge clk_sys) rx_evt <= '0;
	endtask : rxc
	function automatic logic [31:0] st(input logic [31:0] x);
		return x | {side_in.dcc_read_pending, side_in.dcc_write_pending, 17'h0,
			side_in.rx_dma_buffer_full, side_in.tx_dma_buffer_empty, 6'h0,
			side_in.tx_dma_end, side_in.rx_dma_end, 3'h0};
	endfunction : st
	// watcher: results settle by the falling edge
	always @(negedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			end_sim();
		end
		if (rd_q) chk("rdata", eq.pop_front(), bus_rdata);
		if (tx_start) chk("tx_char", cq.pop_front(), {24'h0, tx_char});
		rd_q = bus_req.rd;
	end
	initial begin
		side_in <= 6'($random(seed));
		repeat (20) @(posedge clk_sys);
		sys_rst <= 0;
		wr(OFF_IRQ_SET, 32'hffffffff);
		rd(OFF_IRQ_MASK, IRQ_BITS_MASK);
		n = $random(seed);
		wr(OFF_IRQ_CLR, n);
		wr(OFF_IRQ_SET, 32'h0);
		rd(OFF_IRQ_MASK, IRQ_BITS_MASK & ~n);
		rd(OFF_STATUS, st(32'h0));
		$display("mask and mirrors done");
		wr(OFF_CTRL, 32'h10);
		c = 8'($random(seed));
		rxc(c, 3'h1);
		rd(OFF_STATUS, st(32'h81));
		rd(OFF_RX_HOLD, {24'h0, c});
		rd(OFF_STATUS, st(32'h80));
		rxc(8'h3c, 3'h2);
		rxc(8'hc3, 3'h0);
		rd(OFF_STATUS, st(32'he1));
		wr(OFF_CTRL, 32'h100);
		rd(OFF_STATUS, st(32'h01));
		wr(OFF_CTRL, 32'h20);
		rd(OFF_STATUS, st(32'h0));
		$display("receive done");
		wr(OFF_CTRL, 32'h40);
		rd(OFF_STATUS, st(32'h202));
		// the watcher pops the queue at each launch, so keep each character apart
		c = 8'($random(seed));
		cq.push_back(c);
		wr(OFF_TX_HOLD, {24'h0, c});
		repeat (4) @(posedge clk_sys);
		c = 8'($random(seed));
		cq.push_back(c);
		wr(OFF_TX_HOLD, {24'h0, c});
		rd(OFF_STATUS, st(32'h0));
		// two shifter busy spans must pass before the line is idle
		repeat (80) @(posedge clk_sys);
		rd(OFF_STATUS, st(32'h202));
		chk("tx_sent", 32'h0, cq.size());
		chk("irq", {31'h0, |(st(32'h202) & IRQ_BITS_MASK & ~n)}, {31'h0, irq});
		$display("transmit done");
		wr(OFF_BAUD, 32'h1);
		wr(OFF_BAUD, 32'h5);
		rd(OFF_BAUD, 32'h5);
		rd(8'h24, 32'h0);
		@(negedge clk_sys iff baud_tick);
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while (!baud_tick);
		chk("baud_period", 32'd80, k);
		$display("baud done");
		end_sim();
	end
endmodule : dbu_regs_tb
bind dbu_regs dbu_regs_props dbu_regs_props_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.bus_req(bus_req), .bus_rdata(bus_rdata), .shifter_busy(shifter_busy),
	.tx_start(tx_start), .baud_tick(baud_tick), .rx_enabled(rx_enabled),
	.tx_enabled(tx_enabled), .side_in(side_in));
